// ==== sdsc_pkg.sv ====
// Constants and types for the serial register port of the stepper driver.
// Assumes a 100 MHz system clock and a slow external serial master.
package sdsc_pkg;
  // --------------------------------------------------------------------------
  // Packet layout
  // --------------------------------------------------------------------------
  localparam int unsigned CMD_MSB = 7;
  localparam int unsigned CMD_LSB = 5;
  localparam int unsigned ADR_MSB = 4;
  localparam logic [2:0] CMD_READ = 3'h0;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [5:0] WRITE_BITS = 6'h10;
  localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
  // --------------------------------------------------------------------------
  // Register indices and reset values
  // --------------------------------------------------------------------------
  localparam logic [4:0] ADR_SR0 = 5'h04;
  localparam logic [4:0] ADR_SR1 = 5'h05;
  localparam logic [4:0] ADR_SR2 = 5'h06;
  localparam logic [4:0] ADR_SR3 = 5'h07;
  localparam logic [4:0] ADR_CR0 = 5'h01;
  localparam logic [4:0] ADR_CR1 = 5'h02;
  localparam logic [4:0] ADR_CR2 = 5'h03;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int unsigned SLEEP_BIT = 6;
  localparam int unsigned MOTEN_BIT = 7;
  localparam int unsigned DIRCTRL_BIT = 7;
  // --------------------------------------------------------------------------
  // Shared types
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {SDSC_NONE, SDSC_RD, SDSC_WR} sdsc_op_t;
endpackage

// ==== sdsc_frame_if.sv ====
// Carries one decoded serial event from the receiver to the register core.
// Assumes both ends run on the system clock.
`timescale 1ns/1ps
interface sdsc_frame_if;
  logic sel_n;      // Synchronised chip select, active low.
  logic cmd_pulse;  // One cycle after eighth bit of a command byte.
  logic [7:0] cmd;  // Received command byte.
  logic end_pulse;  // One cycle when select rises.
  logic [5:0] bits; // Bits counted in the finished packet.
  logic [7:0] last; // Last complete byte received.
  logic [7:0] load; // Word for the output shifter.
  logic load_now;   // Load the shifter (eighth falling edge).
  modport rx (output sel_n, cmd_pulse, cmd, end_pulse, bits, last, load_now,
              input load);
  modport core (input sel_n, cmd_pulse, cmd, end_pulse, bits, last, load_now,
                output load);
endinterface

// ==== sdsc_parity.sv ====
// Forms a status byte with odd-count parity in bit 7.
// Assumes seven status bits from the same clock domain.
`timescale 1ns/1ps
module sdsc_parity (
  input wire logic [6:0] i_data,
  output logic [7:0] o_byte
);
  // ----------------------------------------------------------------------
  // Parity: one when an odd number of data bits are set.
  // ----------------------------------------------------------------------
  assign o_byte = {^i_data, i_data};
endmodule // sdsc_parity

// ==== sdsc_rx.sv ====
// Samples the serial pins with the system clock and shifts bytes.
// Assumes the serial clock is far slower than the system clock.
`timescale 1ns/1ps
module sdsc_rx (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_serial_in,
  output logic o_sdo,
  output logic o_sdo_oe,
  sdsc_frame_if.rx fr
);
  typedef struct packed {
    logic [1:0] clk_s;
    logic [1:0] cs_s;
    logic [1:0] din_s;
    logic clk_prev;
    logic [7:0] shin;
    logic [7:0] shout;
    logic [2:0] bitc;
    logic [5:0] total;
    logic cmd_expect;
    logic pend;
    logic cmd_pulse;
    logic end_pulse;
    logic [7:0] cmd;
    logic [7:0] last;
    logic [5:0] bits;
    logic load_now;
  } sdsc_rx_state_t;
  sdsc_rx_state_t q, d;
  logic rise, fall, sel;
  // ----------------------------------------------------------------------
  // Edge detection reads only the second synchroniser stage.
  // ----------------------------------------------------------------------
  assign rise = q.clk_s[1] & ~q.clk_prev;
  assign fall = ~q.clk_s[1] & q.clk_prev;
  assign sel = ~q.cs_s[1];
  always_comb begin
    d = q;
    d.clk_s = {q.clk_s[0], i_sclk};
    d.cs_s = {q.cs_s[0], i_cs_n};
    d.din_s = {q.din_s[0], i_serial_in};
    d.clk_prev = q.clk_s[1];
    d.cmd_pulse = 1'b0;
    d.end_pulse = 1'b0;
    d.load_now = 1'b0;
    if (!sel) begin
      // Select high ends the packet; the next byte is a command again.
      if (q.total != 6'h00 || q.pend) begin
        d.end_pulse = 1'b1;
        d.bits = q.total;
      end
      d.total = 6'h00;
      d.bitc = 3'h0;
      d.cmd_expect = 1'b1;
      d.pend = 1'b0;
    end else begin
      if (rise) begin
        d.shin = {q.shin[6:0], q.din_s[1]};
        d.bitc = q.bitc + 3'h1;
        if (q.total != 6'h3F) begin
          d.total = q.total + 6'h01;
        end
        if (q.bitc == sdsc_pkg::BYTE_LAST_BIT) begin
          d.pend = 1'b1;
        end
      end
      if (fall && q.pend) begin
        // Eighth falling edge: byte is done, reload the output shifter.
        d.pend = 1'b0;
        d.last = q.shin;
        d.load_now = 1'b1;
        if (q.cmd_expect) begin
          d.cmd = q.shin;
          d.cmd_pulse = 1'b1;
          // A read's data byte is itself a new command byte.
          d.cmd_expect = (q.shin[sdsc_pkg::CMD_MSB:sdsc_pkg::CMD_LSB]
                          != sdsc_pkg::CMD_WRITE);
        end else begin
          d.cmd_expect = 1'b1;
        end
      end else if (fall) begin
        d.shout = {q.shout[6:0], 1'b1};
      end
    end
    if (q.load_now) begin
      d.shout = fr.load;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      // Select resets to its idle level, so the output is released in reset.
      q <= '0;
      q.cs_s <= 2'h3;
    end else begin
      q <= d;
    end
  end
  // ----------------------------------------------------------------------
  // Outputs; the line is released while deselected for the pull-up.
  // ----------------------------------------------------------------------
  assign o_sdo = q.shout[7];
  assign o_sdo_oe = sel;
  assign fr.sel_n = q.cs_s[1];
  assign fr.cmd_pulse = q.cmd_pulse;
  assign fr.cmd = q.cmd;
  assign fr.end_pulse = q.end_pulse;
  assign fr.bits = q.bits;
  assign fr.last = q.last;
  assign fr.load_now = q.load_now;
  chk_out_release: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $past(i_cs_n, 2) |-> !o_sdo_oe) else $error("Output driven while deselected.");
  chk_load_fall: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    q.load_now |-> $past(fall)) else $error("Load not on a falling edge.");
endmodule // sdsc_rx

// ==== sdsc_top.sv ====
// Serial register port of the stepper driver with fault and sleep logic.
// Assumes a mode 0 master; pins come asynchronously and are synchronised.
`timescale 1ns/1ps
module sdsc_top (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_hard_reset_in,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_serial_in,
  input wire logic i_step_advance_in,
  input wire logic i_dir_in,
  input wire logic i_pump_low,
  input wire logic i_thermal_warning_flag,
  input wire logic i_thermal_shutdown_flag,
  input wire logic [3:0] i_overcurrent_x_flags,
  input wire logic [3:0] i_overcurrent_y_flags,
  input wire logic [1:0] i_open_coil_flags,
  input wire logic [6:0] i_position,
  output logic o_sdo,
  output logic o_sdo_oe,
  output logic o_fault_n,
  output logic o_fault_oe,
  output logic o_sleep,
  output logic o_drivers_en,
  output logic o_step_advance,
  output logic o_dir,
  output logic [7:0] o_ctrl0,
  output logic [7:0] o_ctrl1,
  output logic [7:0] o_ctrl2
);
  typedef struct packed {
    logic [1:0] hr_s;
    logic [1:0] nx_s;
    logic [1:0] dr_s;
    logic [7:0] cr0;
    logic [7:0] cr1;
    logic [7:0] cr2;
    logic [6:0] sr0;
    logic [6:0] sr1;
    logic [6:0] sr2;
    logic [3:0] rd_mask;
    logic [7:0] wr_cmd;
    logic wr_armed;
    logic [4:0] ptr;
    logic fault;
    logic nxt;
    logic dir;
  } sdsc_core_t;
  sdsc_core_t q, d;
  sdsc_frame_if fr ();
  logic rst, hard_clr;
  logic [7:0] s0_b, s1_b, s2_b, s3_b;
  logic [6:0] ev0, ev1, ev2;
  // ----------------------------------------------------------------------
  // Hard reset input is synchronised; it clears logic unless sleeping.
  // ----------------------------------------------------------------------
  assign hard_clr = q.hr_s[1] & ~q.cr2[sdsc_pkg::SLEEP_BIT];
  assign rst = i_sys_rst | hard_clr;
  sdsc_rx u_rx (
    .i_clk(i_clk),
    .i_sys_rst(rst),
    .i_sclk(i_sclk),
    .i_cs_n(i_cs_n),
    .i_serial_in(i_serial_in),
    .o_sdo(o_sdo),
    .o_sdo_oe(o_sdo_oe),
    .fr(fr.rx)
  );
  sdsc_parity u_p0 (.i_data(q.sr0), .o_byte(s0_b));
  sdsc_parity u_p1 (.i_data(q.sr1), .o_byte(s1_b));
  sdsc_parity u_p2 (.i_data(q.sr2), .o_byte(s2_b));
  sdsc_parity u_p3 (.i_data(i_position), .o_byte(s3_b));
  // Status event vectors; the pump-fail flag sits in status 0.
  assign ev0 = {2'h0, i_thermal_warning_flag, i_pump_low, i_open_coil_flags, 1'b0};
  assign ev1 = {3'h0, i_overcurrent_x_flags};
  assign ev2 = {2'h0, i_thermal_shutdown_flag, i_overcurrent_y_flags};
  // ----------------------------------------------------------------------
  // Register read mux; control reads return raw bytes, no parity.
  // ----------------------------------------------------------------------
  function automatic logic [7:0] rd_mux(input logic [4:0] a, input sdsc_core_t s,
                                        input logic [7:0] b0, input logic [7:0] b1,
                                        input logic [7:0] b2, input logic [7:0] b3);
    if (a == sdsc_pkg::ADR_CR0) begin
      rd_mux = s.cr0;
    end else if (a == sdsc_pkg::ADR_CR1) begin
      rd_mux = s.cr1;
    end else if (a == sdsc_pkg::ADR_CR2) begin
      rd_mux = s.cr2;
    end else if (a == sdsc_pkg::ADR_SR0) begin
      rd_mux = b0;
    end else if (a == sdsc_pkg::ADR_SR1) begin
      rd_mux = b1;
    end else if (a == sdsc_pkg::ADR_SR2) begin
      rd_mux = b2;
    end else if (a == sdsc_pkg::ADR_SR3) begin
      rd_mux = b3;
    end else begin
      rd_mux = 8'h00;
    end
  endfunction
  // Shifter always gets the register of the last received address.
  assign fr.load = rd_mux(fr.cmd[sdsc_pkg::ADR_MSB:0], q, s0_b, s1_b, s2_b, s3_b);
  // ----------------------------------------------------------------------
  // Core next state: writes, status latch and clear, fault, sleep gating.
  // ----------------------------------------------------------------------
  always_comb begin
    d = q;
    d.hr_s = {q.hr_s[0], i_hard_reset_in};
    d.nx_s = {q.nx_s[0], i_step_advance_in};
    d.dr_s = {q.dr_s[0], i_dir_in};
    if (fr.cmd_pulse) begin
      d.ptr = fr.cmd[sdsc_pkg::ADR_MSB:0];
      // Only a read of status register 0, 1 or 2 marks it for clearing.
      if (fr.cmd[sdsc_pkg::CMD_MSB:sdsc_pkg::CMD_LSB] == sdsc_pkg::CMD_READ) begin
        if (fr.cmd[4:0] == sdsc_pkg::ADR_SR0) d.rd_mask[0] = 1'b1;
        if (fr.cmd[4:0] == sdsc_pkg::ADR_SR1) d.rd_mask[1] = 1'b1;
        if (fr.cmd[4:0] == sdsc_pkg::ADR_SR2) d.rd_mask[2] = 1'b1;
      end
      d.wr_armed = (fr.cmd[sdsc_pkg::CMD_MSB:sdsc_pkg::CMD_LSB] == sdsc_pkg::CMD_WRITE);
      d.wr_cmd = fr.cmd;
    end
    if (fr.end_pulse) begin
      d.wr_armed = 1'b0;
      // Write commits on select rising with exactly sixteen bits.
      if (q.wr_armed && fr.bits == sdsc_pkg::WRITE_BITS) begin
        if (q.wr_cmd[4:0] == sdsc_pkg::ADR_CR0) d.cr0 = fr.last;
        else if (q.wr_cmd[4:0] == sdsc_pkg::ADR_CR1) d.cr1 = fr.last;
        else if (q.wr_cmd[4:0] == sdsc_pkg::ADR_CR2) d.cr2 = fr.last;
      end
    end
    if (fr.sel_n) begin
      // Updates happen only while deselected; a new event beats the clear.
      d.sr0 = (q.rd_mask[0] ? 7'h00 : q.sr0) | ev0;
      d.sr1 = (q.rd_mask[1] ? 7'h00 : q.sr1) | ev1;
      d.sr2 = (q.rd_mask[2] ? 7'h00 : q.sr2) | ev2;
      d.rd_mask = 4'h0;
      d.fault = |{d.sr0, d.sr1, d.sr2};
    end
    // Sleep freezes step and direction inputs.
    if (!q.cr2[sdsc_pkg::SLEEP_BIT]) begin
      d.nxt = q.nx_s[1];
      d.dir = q.dr_s[1] ^ q.cr1[sdsc_pkg::DIRCTRL_BIT];
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      q <= '0;
    end else if (hard_clr) begin
      // Keep the hard reset synchroniser running so release is seen.
      q <= '0;
      q.hr_s <= d.hr_s;
    end else begin
      q <= d;
    end
  end
  // ----------------------------------------------------------------------
  // Outputs. Fault is open drain: enable low drive while any bit of status 0, 1 or 2 is latched.
  // ----------------------------------------------------------------------
  assign o_fault_n = 1'b0;
  assign o_fault_oe = q.fault;
  assign o_sleep = q.cr2[sdsc_pkg::SLEEP_BIT];
  assign o_drivers_en = q.cr2[sdsc_pkg::MOTEN_BIT] & ~q.cr2[sdsc_pkg::SLEEP_BIT];
  assign o_step_advance = q.nxt;
  assign o_dir = q.dir;
  assign o_ctrl0 = q.cr0;
  assign o_ctrl1 = q.cr1;
  assign o_ctrl2 = q.cr2;
  // ----------------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------------
  sequence s_write_end;
    fr.end_pulse && q.wr_armed && fr.bits == sdsc_pkg::WRITE_BITS
      && q.wr_cmd[4:0] == sdsc_pkg::ADR_CR2;
  endsequence
  chk_write_commit: assert property (@(posedge i_clk) disable iff (rst)
    s_write_end |=> q.cr2 == $past(fr.last)) else $error("Write not stored.");
  chk_short_write: assert property (@(posedge i_clk) disable iff (rst)
    fr.end_pulse && fr.bits != sdsc_pkg::WRITE_BITS |=> $stable(q.cr2))
    else $error("Bad length write stored.");
  chk_status_hold: assert property (@(posedge i_clk) disable iff (rst)
    !fr.sel_n |=> $stable(q.sr0) && $stable(q.fault))
    else $error("Status changed while selected.");
  chk_fault_pin: assert property (@(posedge i_clk) disable iff (rst)
    fr.sel_n && i_pump_low |=> o_fault_oe) else $error("Fault not raised.");
  chk_sleep_freeze: assert property (@(posedge i_clk) disable iff (rst)
    q.cr2[sdsc_pkg::SLEEP_BIT] |=> $stable(o_step_advance))
    else $error("Step input seen in sleep.");
  chk_drv_sleep: assert property (@(posedge i_clk) disable iff (rst)
    o_sleep |-> !o_drivers_en) else $error("Drivers on in sleep.");
endmodule // sdsc_top

// ==== sdsc_master.sv ====
// Serial master model that drives packets into the stepper driver port.
// Assumes the bench feeds i_sdo through a pull-up when the slave lets go.
`timescale 1ns/1ps
module sdsc_master (
  input wire logic i_clk,
  input wire logic i_sdo,
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_mosi
);
  localparam int HALF = 4; // Four cycles a phase give the 80 ns serial clock.
  // Idle bus: select high, clock low.
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end
  // One packet of n bits from the low end of tx; the line is read before each rise.
  task automatic xfer(input int n, input logic [23:0] tx, output logic [23:0] rx);
    rx = 24'h000000;
    @(negedge i_clk);
    o_cs_n = 1'b0;
    repeat (2 * HALF) @(negedge i_clk);
    for (int i = 0; i < n; i++) begin
      o_mosi = tx[n-1-i];
      repeat (HALF) @(negedge i_clk);
      rx = {rx[22:0], i_sdo};
      o_sclk = 1'b1;
      repeat (HALF) @(negedge i_clk);
      o_sclk = 1'b0;
    end
    repeat (2 * HALF) @(negedge i_clk);
    o_cs_n = 1'b1;
    o_mosi = ~o_mosi; // A released line must not keep showing its last bit.
    repeat (3 * HALF) @(negedge i_clk);
  endtask
endmodule // sdsc_master

// ==== stepper_driver_spi_slave_ctrl_bench.sv ====
// Self-checking bench for the stepper driver serial port, fault and sleep logic.
// Assumes the design files and sdsc_master are compiled first.
`timescale 1ns/1ps
module stepper_driver_spi_slave_ctrl_bench;
  localparam int PUMP_WAIT = 50; // Plain stand-in for the pump startup time.
  logic clk = 1'b0, rst = 1'b1, hrst = 1'b0, step = 1'b0, dir = 1'b0, pump = 1'b1;
  logic tw = 1'b0, thermal_shutdown_flag = 1'b0;
  logic [3:0] ox = 4'h0, oy = 4'h0;
  logic [1:0] oc = 2'h0;
  logic [6:0] pos = 7'h00;
  logic sclk, cs_n, mosi, sdo, sdo_oe, fault_n, fault_oe, slp, drv_en, step_o, dir_o;
  logic sdo_w, fault_w;
  logic [7:0] c0, c1, c2, got;
  logic [23:0] r;
  logic [4:0] a;
  logic [6:0] e;
  int bad_count = 0, cmp_count = 0, cyc = 0;
  // Clock and pull-ups on the two released lines.
  always #5 clk = ~clk;
  assign sdo_w = sdo_oe ? sdo : 1'b1;
  assign fault_w = fault_oe ? fault_n : 1'b1;
  sdsc_master m_u (.i_clk(clk), .i_sdo(sdo_w), .o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi));
  sdsc_top dut_u (.i_clk(clk), .i_sys_rst(rst), .i_hard_reset_in(hrst), .i_sclk(sclk),
    .i_cs_n(cs_n), .i_serial_in(mosi), .i_step_advance_in(step), .i_dir_in(dir),
    .i_pump_low(pump), .i_thermal_warning_flag(tw), .i_thermal_shutdown_flag(thermal_shutdown_flag),
    .i_overcurrent_x_flags(ox), .i_overcurrent_y_flags(oy), .i_open_coil_flags(oc),
    .i_position(pos), .o_sdo(sdo), .o_sdo_oe(sdo_oe), .o_fault_n(fault_n),
    .o_fault_oe(fault_oe), .o_sleep(slp), .o_drivers_en(drv_en), .o_step_advance(step_o),
    .o_dir(dir_o), .o_ctrl0(c0), .o_ctrl1(c1), .o_ctrl2(c2));
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [7:0] par(input logic [6:0] d);
    return {^d, d};
  endfunction
  // Read one register; the serial output line must be released afterwards.
  task automatic rd(input logic [4:0] adr, output logic [7:0] d);
    logic [23:0] rx;
    m_u.xfer(16, {8'h00, sdsc_pkg::CMD_READ, adr, 8'h00}, rx);
    d = rx[7:0];
    check("sdo_oe", sdo_oe, 8'h00);
  endtask
  // Write with a chosen bit count; the top n bits of the 16-bit word plus zeros are sent.
  task automatic wr(input logic [4:0] adr, input logic [7:0] d, input int n, output logic [7:0] o);
    logic [23:0] rx;
    m_u.xfer(n, {sdsc_pkg::CMD_WRITE, adr, d, 8'h00} >> (24 - n), rx);
    o = rx[7:0];
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // A hung run counts as a mismatch and closes the report.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      end_of_test();
    end
  end
  // Main sequence.
  initial begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    check("ctrl0", c0, 8'h00);
    check("ctrl2", c2, 8'h00);
    check("fault", fault_w, 8'h00);
    pump = 1'b0;
    rd(sdsc_pkg::ADR_SR0, got);
    check("sr0", got, 8'h88);
    rd(sdsc_pkg::ADR_SR0, got);
    check("sr0 clr", got, 8'h00);
    check("fault", fault_w, 8'h01);
    for (int k = 0; k < 6; k++) begin
      @(negedge clk);
      case (k)
        0: begin tw = 1'b1; a = sdsc_pkg::ADR_SR0; e = 7'h10; end
        1: begin oc = 2'h3; a = sdsc_pkg::ADR_SR0; e = 7'h06; end
        2: begin ox = 4'hF; a = sdsc_pkg::ADR_SR1; e = 7'h0F; end
        3: begin ox = 4'h1; a = sdsc_pkg::ADR_SR1; e = 7'h01; end
        4: begin thermal_shutdown_flag = 1'b1; a = sdsc_pkg::ADR_SR2; e = 7'h10; end
        default: begin oy = 4'h7; a = sdsc_pkg::ADR_SR2; e = 7'h07; end
      endcase
      @(negedge clk);
      {tw, thermal_shutdown_flag, ox, oy, oc} = 12'h000;
      repeat (4) @(negedge clk);
      check("fault", fault_w, 8'h00);
      rd(a, got);
      check("status", got, par(e));
      rd(a, got);
      check("status clr", got, 8'h00);
      check("fault", fault_w, 8'h01);
    end
    pos = 7'h07;
    rd(sdsc_pkg::ADR_SR3, got);
    check("sr3", got, par(pos));
    wr(sdsc_pkg::ADR_CR0, 8'h25, 16, got);
    check("old cr0", got, 8'h00);
    check("ctrl0", c0, 8'h25);
    wr(sdsc_pkg::ADR_CR1, 8'h80, 15, got);
    wr(sdsc_pkg::ADR_CR1, 8'h80, 17, got);
    check("ctrl1", c1, 8'h00);
    wr(sdsc_pkg::ADR_SR0, 8'h7F, 16, got);
    rd(sdsc_pkg::ADR_SR0, got);
    check("sr0 ro", got, 8'h00);
    check("ctrl0", c0, 8'h25);
    wr(sdsc_pkg::ADR_CR1, 8'h80, 16, got);
    check("ctrl1", c1, 8'h80);
    m_u.xfer(24, {sdsc_pkg::CMD_READ, sdsc_pkg::ADR_CR0, sdsc_pkg::CMD_READ,
      sdsc_pkg::ADR_CR1, 8'h00}, r);
    check("chain cr0", r[15:8], 8'h25);
    check("chain cr1", r[7:0], 8'h80);
    wr(sdsc_pkg::ADR_CR2, 8'hC0, 16, got);
    check("sleep", slp, 8'h01);
    check("drv_en", drv_en, 8'h00);
    step = 1'b1;
    dir = 1'b1;
    repeat (8) @(negedge clk);
    check("step", step_o, 8'h00);
    check("dir", dir_o, 8'h01);
    rd(sdsc_pkg::ADR_CR0, got);
    check("cr0 sleep", got, 8'h25);
    hrst = 1'b1;
    repeat (10) @(negedge clk);
    hrst = 1'b0;
    repeat (10) @(negedge clk);
    check("ctrl0", c0, 8'h25);
    check("ctrl2", c2, 8'hC0);
    wr(sdsc_pkg::ADR_CR2, 8'h80, 16, got);
    check("sleep", slp, 8'h00);
    check("drv_en", drv_en, 8'h01);
    repeat (PUMP_WAIT) @(negedge clk);
    check("step", step_o, 8'h01);
    check("dir", dir_o, 8'h00);
    hrst = 1'b1;
    repeat (10) @(negedge clk);
    check("ctrl0", c0, 8'h00);
    check("sdo_oe hrst", sdo_oe, 8'h00);
    hrst = 1'b0;
    repeat (10) @(negedge clk);
    check("ctrl1", c1, 8'h00);
    check("ctrl2", c2, 8'h00);
    rd(sdsc_pkg::ADR_CR0, got);
    check("cr0", got, 8'h00);
    end_of_test();
  end
endmodule // stepper_driver_spi_slave_ctrl_bench
